// file: design/pdpsc_pkg.sv
package pdpsc_pkg;
   // Power states; deep idle is a flavour of idle, not a state of its own
   typedef enum logic [1:0] {
      PDPSC_ACTIVE,
      PDPSC_IDLE,
      PDPSC_SLEEP
   } pdpsc_state_t;

   // Boot sequence
   typedef enum logic [2:0] {
      PDPSC_B_STRAP,
      PDPSC_B_EE_REQ,
      PDPSC_B_EE_WAIT,
      PDPSC_B_HOST_WAIT,
      PDPSC_B_DONE
   } pdpsc_boot_t;

   // CC termination codes
   localparam logic [1:0] PDPSC_CC_OPEN = 2'h0;
   localparam logic [1:0] PDPSC_CC_RD   = 2'h1;
   localparam logic [1:0] PDPSC_CC_RP3A = 2'h2;

   // EEPROM target address, 7 bits
   localparam logic [6:0] PDPSC_EEPROM_ADDR = 7'h50;

   // Strap width
   localparam int PDPSC_STRAP_W = 6;

   // Clock and inactivity timeout
   localparam int PDPSC_CLK_NS         = 100;
   localparam int PDPSC_IDLE_T_MS      = 100;
   localparam int PDPSC_IDLE_T_CYC     = (PDPSC_IDLE_T_MS * 1000000) / PDPSC_CLK_NS;
   // Sleep entry after a further quiet interval in idle with no attach
   localparam int PDPSC_SLEEP_T_MS     = 100;
   localparam int PDPSC_SLEEP_T_CYC    = (PDPSC_SLEEP_T_MS * 1000000) / PDPSC_CLK_NS;
   localparam int PDPSC_TMR_W          = 24;
endpackage

// file: design/pdpsc_timer.sv
`timescale 1ns/10ps
module pdpsc_timer (
   // Clock and reset
   input  wire logic                               clk,
   input  wire logic                               nrst,
   // Control
   input  wire logic                               restart,
   input  wire logic                               run,
   input  wire logic [pdpsc_pkg::PDPSC_TMR_W-1:0]  limit,
   // Status
   output logic                                    expired
);
   import pdpsc_pkg::*;

   logic [PDPSC_TMR_W-1:0] count;

   // Counter holds at the limit so expiry stays a level until restarted
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (restart || !run) begin
         count <= '0;
      end else if (count != limit) begin
         count <= count + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         expired <= 1'b0;
      end else begin
         expired <= run && !restart && (count == limit);
      end
   end
endmodule

// file: design/pdpsc_ctrl.sv
// How it works
// - The block keeps one of three power states: active, idle and sleep.
// - The state moves on its own from activity and attach inputs, with no software command.
// - Deep idle is idle with the deep-idle request set, not a fourth state.
// - In sleep, an attach seen on the config lines wakes the block back to active.
// - Active falls to idle only after the full timeout with no activity of any listed kind.
// - Source roles turn on both source and cable switches, sink roles both sink gates and cable switches.
// - Deep idle keeps only the port A source switch while sourcing, and leaves port B config lines open.
// - Die over-temperature turns off every switch and termination, leaving only supervision running.
// - Once die temperature falls below hysteresis, normal outputs come back by themselves.
// - Either path over-temperature turns off both source switches and both cable switches.
// - After path hysteresis, a setting picks auto resume or hold off until firmware re-enables.
// - At boot the configuration comes from the EEPROM or from the host port.
// - The host port may load configuration, but no host command reaches the power state machine.
// - Boot samples the straps first, then reads the EEPROM if one is present, else waits for the host.
// - The EEPROM is always read at one fixed 7-bit target address.
`timescale 1ns/10ps
module pdpsc_ctrl #(
   parameter logic [pdpsc_pkg::PDPSC_TMR_W-1:0] IDLE_CYCLES  =
      pdpsc_pkg::PDPSC_IDLE_T_CYC[pdpsc_pkg::PDPSC_TMR_W-1:0],
   parameter logic [pdpsc_pkg::PDPSC_TMR_W-1:0] SLEEP_CYCLES =
      pdpsc_pkg::PDPSC_SLEEP_T_CYC[pdpsc_pkg::PDPSC_TMR_W-1:0]
) (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                nrst,
   // Activity sources, one-cycle pulses
   input  wire logic                                pd_msg_in,
   input  wire logic                                cc_change,
   input  wire logic                                gpio_event,
   input  wire logic                                i2c_txn,
   input  wire logic                                voltage_alert,
   input  wire logic                                fault_alert,
   // Attach and role
   input  wire logic                                attach_detect,
   input  wire logic                                attached,
   input  wire logic                                sink_role,
   input  wire logic                                deep_idle_req,
   // Thermal indications, levels
   input  wire logic                                die_over_temp,
   input  wire logic                                die_below_hyst,
   input  wire logic                                path_a_over_temp,
   input  wire logic                                path_b_over_temp,
   input  wire logic                                path_below_hyst,
   input  wire logic                                path_auto_resume,
   input  wire logic                                path_fw_reenable,
   // Boot
   input  wire logic [pdpsc_pkg::PDPSC_STRAP_W-1:0] strap_inputs,
   input  wire logic                                eeprom_present,
   input  wire logic                                eeprom_done,
   input  wire logic                                host_cfg_loaded,
   output logic                                     eeprom_read_req,
   output logic [6:0]                               eeprom_addr,
   output logic [pdpsc_pkg::PDPSC_STRAP_W-1:0]      strap_latched,
   output logic                                     cfg_from_eeprom,
   output logic                                     boot_done,
   // Power switches
   output logic                                     port_a_source_switch,
   output logic                                     port_b_source_switch,
   output logic                                     port_a_sink_gate,
   output logic                                     port_b_sink_gate,
   output logic                                     port_a_cable_power_switch,
   output logic                                     port_b_cable_power_switch,
   // CC terminations
   output logic [1:0]                               port_a_config_line1,
   output logic [1:0]                               port_a_config_line2,
   output logic [1:0]                               port_b_config_line1,
   output logic [1:0]                               port_b_config_line2,
   // Status
   output pdpsc_pkg::pdpsc_state_t                  power_state,
   output logic                                     deep_idle,
   output logic                                     die_shutdown,
   output logic                                     path_shutdown
);
   import pdpsc_pkg::*;

   pdpsc_state_t state;
   pdpsc_state_t next_state;
   pdpsc_boot_t  boot;
   pdpsc_boot_t  next_boot;
   logic         activity;
   logic         idle_expired;
   logic         sleep_expired;
   logic         path_trip;
   logic         src_role;
   logic         snk_role;
   logic         deep;

   assign activity  = pd_msg_in | cc_change | gpio_event | i2c_txn | voltage_alert | fault_alert;
   assign path_trip = path_a_over_temp | path_b_over_temp;

   // Inactivity timer runs only in active
   pdpsc_timer u_idle_timer (
      .clk     (clk),
      .nrst    (nrst),
      .restart (activity),
      .run     (state == PDPSC_ACTIVE && boot == PDPSC_B_DONE),
      .limit   (IDLE_CYCLES),
      .expired (idle_expired)
   );

   // Sleep only once idle has stayed quiet with nothing attached
   pdpsc_timer u_sleep_timer (
      .clk     (clk),
      .nrst    (nrst),
      .restart (activity),
      .run     (state == PDPSC_IDLE && !attached),
      .limit   (SLEEP_CYCLES),
      .expired (sleep_expired)
   );

   // Boot sequence
   always_comb begin
      next_boot = boot;
      unique case (boot)
         PDPSC_B_STRAP: begin
            next_boot = PDPSC_B_EE_REQ;
         end
         PDPSC_B_EE_REQ: begin
            next_boot = eeprom_present ? PDPSC_B_EE_WAIT : PDPSC_B_HOST_WAIT;
         end
         PDPSC_B_EE_WAIT: begin
            if (eeprom_done) begin
               next_boot = PDPSC_B_DONE;
            end
         end
         PDPSC_B_HOST_WAIT: begin
            if (host_cfg_loaded) begin
               next_boot = PDPSC_B_DONE;
            end
         end
         PDPSC_B_DONE: begin
            next_boot = PDPSC_B_DONE;
         end
         default: begin
            next_boot = PDPSC_B_STRAP;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         boot <= PDPSC_B_STRAP;
      end else begin
         boot <= next_boot;
      end
   end

   // Straps are caught after reset release, never by the reset itself
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_latched <= '0;
      end else if (boot == PDPSC_B_STRAP) begin
         strap_latched <= strap_inputs;
      end
   end

   // Address held at zero in reset so no transfer can start before boot runs
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eeprom_read_req <= 1'b0;
         eeprom_addr     <= '0;
         cfg_from_eeprom <= 1'b0;
         boot_done       <= 1'b0;
      end else begin
         eeprom_read_req <= (next_boot == PDPSC_B_EE_WAIT);
         eeprom_addr     <= PDPSC_EEPROM_ADDR;
         if (boot == PDPSC_B_EE_WAIT && eeprom_done) begin
            cfg_from_eeprom <= 1'b1;
         end
         boot_done <= (next_boot == PDPSC_B_DONE);
      end
   end

   // Power state machine; no software input reaches it
   always_comb begin
      next_state = state;
      unique case (state)
         PDPSC_ACTIVE: begin
            if (idle_expired && !activity) begin
               next_state = PDPSC_IDLE;
            end
         end
         PDPSC_IDLE: begin
            if (activity || attach_detect) begin
               next_state = PDPSC_ACTIVE;
            end else if (sleep_expired) begin
               next_state = PDPSC_SLEEP;
            end
         end
         PDPSC_SLEEP: begin
            if (attach_detect) begin
               next_state = PDPSC_ACTIVE;
            end
         end
         default: begin
            next_state = PDPSC_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= PDPSC_ACTIVE;
      end else begin
         state <= next_state;
      end
   end

   // Die shutdown follows the comparator with its own hysteresis
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         die_shutdown <= 1'b0;
      end else if (die_over_temp) begin
         die_shutdown <= 1'b1;
      end else if (die_below_hyst) begin
         die_shutdown <= 1'b0;
      end
   end

   // Path latch; a new trip wins over a release in the same cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         path_shutdown <= 1'b0;
      end else if (path_trip) begin
         path_shutdown <= 1'b1;
      end else if (path_below_hyst && (path_auto_resume || path_fw_reenable)) begin
         path_shutdown <= 1'b0;
      end
   end

   // Outputs stay off until a configuration is in place
   assign deep     = (state == PDPSC_IDLE) && deep_idle_req;
   assign src_role = attached && !sink_role && boot == PDPSC_B_DONE && state != PDPSC_SLEEP && !die_shutdown;
   assign snk_role = attached && sink_role && boot == PDPSC_B_DONE && state != PDPSC_SLEEP && !die_shutdown;

   // Source switches; the raw trip also gates so power drops one edge after a trip
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_a_source_switch <= 1'b0;
         port_b_source_switch <= 1'b0;
      end else begin
         port_a_source_switch <= src_role && !path_shutdown && !path_trip;
         port_b_source_switch <= src_role && !deep && !path_shutdown && !path_trip;
      end
   end

   // Sink gates; the sink path is external, so path trips leave it alone
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_a_sink_gate <= 1'b0;
         port_b_sink_gate <= 1'b0;
      end else begin
         port_a_sink_gate <= snk_role && !deep;
         port_b_sink_gate <= snk_role && !deep;
      end
   end

   // Cable power shares the supply of the source paths and their trip
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_a_cable_power_switch <= 1'b0;
         port_b_cable_power_switch <= 1'b0;
      end else begin
         port_a_cable_power_switch <= (src_role || snk_role) && !deep && !path_shutdown && !path_trip;
         port_b_cable_power_switch <= (src_role || snk_role) && !deep && !path_shutdown && !path_trip;
      end
   end

   // Terminations; line 2 never driven since orientation handling sits elsewhere
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_a_config_line1 <= PDPSC_CC_OPEN;
         port_a_config_line2 <= PDPSC_CC_OPEN;
      end else begin
         port_a_config_line1 <= src_role ? PDPSC_CC_RD : (snk_role ? PDPSC_CC_RP3A : PDPSC_CC_OPEN);
         port_a_config_line2 <= PDPSC_CC_OPEN;
      end
   end

   // Port B opens fully in deep idle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_b_config_line1 <= PDPSC_CC_OPEN;
         port_b_config_line2 <= PDPSC_CC_OPEN;
      end else begin
         port_b_config_line1 <= deep ? PDPSC_CC_OPEN :
                                (src_role ? PDPSC_CC_RD : (snk_role ? PDPSC_CC_RP3A : PDPSC_CC_OPEN));
         port_b_config_line2 <= PDPSC_CC_OPEN;
      end
   end

   // Status taken from the next state so it lines up with the state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_state <= PDPSC_ACTIVE;
         deep_idle   <= 1'b0;
      end else begin
         power_state <= next_state;
         deep_idle   <= (next_state == PDPSC_IDLE) && deep_idle_req;
      end
   end
endmodule

// file: tb/pdpsc_ctrl_asserts.sv
`timescale 1ns/10ps
module pdpsc_ctrl_chk #(
   parameter int IDLE_CYCLES = 20
) (
   // Clock and reset
   input wire logic                    clk,
   input wire logic                    nrst,
   // Activity and attach
   input wire logic                    pd_msg_in,
   input wire logic                    cc_change,
   input wire logic                    gpio_event,
   input wire logic                    i2c_txn,
   input wire logic                    voltage_alert,
   input wire logic                    fault_alert,
   input wire logic                    attach_detect,
   // Thermal
   input wire logic                    die_over_temp,
   input wire logic                    die_below_hyst,
   input wire logic                    path_a_over_temp,
   input wire logic                    path_b_over_temp,
   input wire logic                    path_below_hyst,
   // Switches and terminations
   input wire logic                    port_a_source_switch,
   input wire logic                    port_b_source_switch,
   input wire logic                    port_a_sink_gate,
   input wire logic                    port_b_sink_gate,
   input wire logic                    port_a_cable_power_switch,
   input wire logic                    port_b_cable_power_switch,
   input wire logic [1:0]              port_a_config_line1,
   input wire logic [1:0]              port_a_config_line2,
   input wire logic [1:0]              port_b_config_line1,
   input wire logic [1:0]              port_b_config_line2,
   // Status
   input wire pdpsc_pkg::pdpsc_state_t power_state,
   input wire logic                    die_shutdown,
   input wire logic                    path_shutdown
);
   import pdpsc_pkg::*;
   logic [23:0] quiet;
   logic        act;
   logic        pwr_on;
   logic        sw_off;
   logic        cc_open;
   assign act = pd_msg_in | cc_change | gpio_event | i2c_txn | voltage_alert | fault_alert;
   assign pwr_on = port_a_source_switch | port_b_source_switch | port_a_cable_power_switch | port_b_cable_power_switch;
   assign sw_off = !(pwr_on | port_a_sink_gate | port_b_sink_gate);
   assign cc_open = {port_a_config_line1, port_a_config_line2, port_b_config_line1, port_b_config_line2} == 8'h00;
   // Quiet edges in active; also counts during boot, so it never undercounts the timer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         quiet <= 24'h0;
      end else begin
         quiet <= (act || power_state != PDPSC_ACTIVE) ? 24'h0 : quiet + 24'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_asleep;
      power_state == PDPSC_SLEEP;
   endsequence
   sequence s_wake;
      s_asleep ##0 attach_detect;
   endsequence
   a_sleep_wake: assert property (s_wake |=> power_state == PDPSC_ACTIVE)
      else $error("sleep did not wake on attach");
   a_sleep_hold: assert property (s_asleep ##0 !attach_detect |=> s_asleep)
      else $error("sleep left without attach");
   a_sleep_dark: assert property (s_asleep ##1 s_asleep |-> sw_off && cc_open)
      else $error("output live in sleep");
   a_idle_wake: assert property (power_state == PDPSC_IDLE && (act || attach_detect) |=> power_state == PDPSC_ACTIVE)
      else $error("idle ignored activity");
   a_idle_early: assert property (power_state == PDPSC_ACTIVE && (act || quiet < IDLE_CYCLES) |=> power_state != PDPSC_IDLE)
      else $error("idle entered too soon");
   a_line2_open: assert property (port_a_config_line2 == PDPSC_CC_OPEN && port_b_config_line2 == PDPSC_CC_OPEN)
      else $error("line 2 not open");
   a_die_trip: assert property (die_over_temp |=> die_shutdown)
      else $error("die trip missed");
   a_die_dark: assert property (die_shutdown && $past(die_shutdown) |-> sw_off && cc_open)
      else $error("output live in die shutdown");
   a_die_resume: assert property (die_shutdown && die_below_hyst && !die_over_temp |=> !die_shutdown)
      else $error("die shutdown stuck");
   a_path_trip: assert property (path_a_over_temp || path_b_over_temp |=> !pwr_on)
      else $error("path trip left power on");
   a_path_hold: assert property (path_shutdown && !path_below_hyst |=> path_shutdown)
      else $error("path released while hot");
endmodule
bind pdpsc_ctrl pdpsc_ctrl_chk #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (.*);

// file: tb/pdpsc_boot_peer.sv
`timescale 1ns/10ps
module pdpsc_boot_peer (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Boot handshake
   input wire logic       use_ee,
   input wire logic       eeprom_read_req,
   input wire logic       boot_done,
   input wire logic [6:0] eeprom_addr,
   output logic           eeprom_present,
   output logic           eeprom_done,
   output logic           host_cfg_loaded
);
   logic [3:0] cnt;
   assign eeprom_present = use_ee;
   // Answers late on purpose, so the device must really wait in the EEPROM or host wait step
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 4'h0;
         eeprom_done <= 1'b0;
         host_cfg_loaded <= 1'b0;
      end else begin
         cnt <= boot_done ? 4'h0 : cnt + 4'h1;
         eeprom_done <= eeprom_read_req && eeprom_addr == 7'h50 && cnt == 4'h5;
         host_cfg_loaded <= !use_ee && cnt == 4'h9;
      end
   end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   import pdpsc_pkg::*;
   logic clk = 0, nrst = 0, attach_detect = 0, attached = 1, sink_role = 0, deep_idle_req = 0, use_ee = 1;
   logic die_over_temp = 0, die_below_hyst = 1, path_a_over_temp = 0, path_b_over_temp = 0;
   logic path_below_hyst = 1, path_auto_resume = 0, path_fw_reenable = 0;
   logic pd_msg_in, cc_change, gpio_event, i2c_txn, voltage_alert, fault_alert;
   logic eeprom_present, eeprom_done, host_cfg_loaded, eeprom_read_req, cfg_from_eeprom, boot_done;
   logic port_a_source_switch, port_b_source_switch, port_a_sink_gate, port_b_sink_gate;
   logic port_a_cable_power_switch, port_b_cable_power_switch, deep_idle, die_shutdown, path_shutdown;
   logic [1:0] port_a_config_line1, port_a_config_line2, port_b_config_line1, port_b_config_line2;
   logic [6:0] eeprom_addr;
   logic [5:0] strap_inputs = 6'h2a;
   logic [5:0] strap_latched;
   logic [5:0] act = 6'h0;
   pdpsc_state_t power_state;
   int err_total = 0;
   int n_checks = 0;
   // Role, deep, idle, then switches a/b source, a/b sink, a/b cable, CC1 a, CC1 b
   logic [12:0] rows [6] = '{13'h0335, 13'h10fa, 13'h0735, 13'h14fa, 13'h0e04, 13'h1c08};
   wire [9:0] sw = {port_a_source_switch, port_b_source_switch, port_a_sink_gate, port_b_sink_gate,
                    port_a_cable_power_switch, port_b_cable_power_switch, port_a_config_line1, port_b_config_line1};
   assign {fault_alert, voltage_alert, i2c_txn, gpio_event, cc_change, pd_msg_in} = act;
   pdpsc_ctrl #(.IDLE_CYCLES(24'h14), .SLEEP_CYCLES(24'h1e)) DUT (.*);
   pdpsc_boot_peer u_peer (.*);
   initial begin
      forever #50 clk = ~clk;
   end
   task test_done;
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Bounded wait on boot_done (b set) or on the power state
   task wait_for(input bit b, input logic [1:0] v, input int lim);
      for (int i = 0; i < lim && (b ? {1'b0, boot_done} : 2'(power_state)) !== v; i++) @(negedge clk);
      if ((b ? {1'b0, boot_done} : 2'(power_state)) !== v) begin
         err_total++;
         $display("mismatch at %0t: wait ran out", $time);
         test_done();
      end
   endtask
   task pulse(input int i);
      @(posedge clk);
      act[i] <= 1'b1;
      @(posedge clk);
      act[i] <= 1'b0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      tick(1);
      chk({power_state, sw}, 12'h0);
      @(posedge clk);
      nrst <= 1'b1;
      wait_for(1, 2'h1, 20);
      chk({cfg_from_eeprom, strap_latched, eeprom_addr, eeprom_read_req}, 15'h6aa0);
      for (int r = 0; r < 6; r++) begin
         @(posedge clk);
         sink_role <= rows[r][12];
         deep_idle_req <= rows[r][11];
         pulse(r);
         tick(1);
         chk(power_state, PDPSC_ACTIVE);
         if (rows[r][10]) wait_for(0, 2'h1, 60);
         tick(3);
         chk(sw, rows[r][9:0]);
         chk(deep_idle, rows[r][11] & rows[r][10]);
      end
      pulse(1);
      repeat (12) begin tick(1); chk(power_state, PDPSC_ACTIVE); end
      pulse(5);
      repeat (19) begin tick(1); chk(power_state, PDPSC_ACTIVE); end
      wait_for(0, 2'h1, 10);
      @(posedge clk);
      attached <= 1'b0;
      deep_idle_req <= 1'b0;
      wait_for(0, 2'h2, 80);
      tick(2);
      chk(sw, 10'h0);
      pulse(2);
      tick(2);
      chk(power_state, PDPSC_SLEEP);
      @(posedge clk);
      attach_detect <= 1'b1;
      attached <= 1'b1;
      sink_role <= 1'b0;
      @(posedge clk);
      attach_detect <= 1'b0;
      tick(1);
      chk(power_state, PDPSC_ACTIVE);
      @(posedge clk);
      die_over_temp <= 1'b1;
      die_below_hyst <= 1'b0;
      tick(3);
      chk({die_shutdown, sw}, 11'h400);
      @(posedge clk);
      die_over_temp <= 1'b0;
      tick(3);
      chk(die_shutdown, 1'b1);
      @(posedge clk);
      die_below_hyst <= 1'b1;
      tick(3);
      chk({die_shutdown, sw}, 11'h335);
      // Manual release first, then the auto-resume setting
      @(posedge clk);
      path_a_over_temp <= 1'b1;
      path_below_hyst <= 1'b0;
      tick(3);
      chk({path_shutdown, sw}, 11'h405);
      @(posedge clk);
      path_a_over_temp <= 1'b0;
      path_below_hyst <= 1'b1;
      tick(3);
      chk(path_shutdown, 1'b1);
      @(posedge clk);
      path_fw_reenable <= 1'b1;
      @(posedge clk);
      path_fw_reenable <= 1'b0;
      tick(3);
      chk({path_shutdown, sw}, 11'h335);
      @(posedge clk);
      path_auto_resume <= 1'b1;
      path_b_over_temp <= 1'b1;
      path_below_hyst <= 1'b0;
      tick(3);
      chk(sw, 10'h005);
      @(posedge clk);
      path_b_over_temp <= 1'b0;
      path_below_hyst <= 1'b1;
      tick(3);
      chk({path_shutdown, sw}, 11'h335);
      @(posedge clk);
      use_ee <= 1'b0;
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      tick(1);
      chk({power_state, sw, die_shutdown, path_shutdown, boot_done}, 15'h0);
      @(posedge clk);
      nrst <= 1'b1;
      wait_for(1, 2'h1, 40);
      chk({cfg_from_eeprom, eeprom_read_req}, 2'h0);
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule
